// file: design/pbas_bus_sampler.sv
`timescale 1ns/1ps
`include "pbas_regs.svh"
module pbas_bus_sampler
  import pbas_pkg::*;
#(
  parameter int DESKEW_CYC = `PBAS_DESKEW_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic bsyIn,
  input wire logic selIn,
  input wire logic rstIn,
  input wire logic cdIn,
  input wire logic ioIn,
  input wire logic reqIn,
  input wire logic msgIn,
  input wire pbas_byte_t dataIn,
  input wire logic parIn,
  output logic bsyA,
  output logic selA,
  output logic rstA,
  output logic cdA,
  output logic ioA,
  output logic reqA,
  output logic msgA,
  output pbas_byte_t dataA,
  output logic parA,
  output logic busFree
);
  // ------------------------------------------------------------------------
  // Line capture
  // ------------------------------------------------------------------------
  // A low level means asserted, so every line is inverted once here and the
  // rest of the controller works with asserted-high values.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {bsyA, selA, rstA, cdA, ioA, reqA, msgA, parA} <= 8'h00;
      dataA <= 8'h00;
    end else begin
      {bsyA, selA, rstA} <= ~{bsyIn, selIn, rstIn};
      {cdA, ioA, reqA, msgA} <= ~{cdIn, ioIn, reqIn, msgIn};
      dataA <= ~dataIn;
      parA <= ~parIn;
    end
  end

  // ------------------------------------------------------------------------
  // Bus free qualification
  // ------------------------------------------------------------------------
  pbas_tmr_t freeCnt_reg; // Cycles with busy and select both released.

  // The bus counts as free only once busy and select have both stayed
  // released for a deskew delay with reset inactive; a glitch restarts it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      freeCnt_reg <= '0;
    end else if (bsyA || selA || rstA) begin
      freeCnt_reg <= '0;
    end else if (freeCnt_reg != pbas_tmr_t'(DESKEW_CYC)) begin
      freeCnt_reg <= freeCnt_reg + pbas_tmr_t'(1);
    end
  end

  assign busFree = (freeCnt_reg == pbas_tmr_t'(DESKEW_CYC));
endmodule

// file: design/pbas_delay_timer.sv
`timescale 1ns/1ps
`include "pbas_regs.svh"
module pbas_delay_timer
  import pbas_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire pbas_tmr_t loadVal,
  output logic done
);
  // ------------------------------------------------------------------------
  // Down counter
  // ------------------------------------------------------------------------
  pbas_tmr_t cnt_reg; // Cycles still to wait.

  // Loading N makes done rise N cycles after the load edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= loadVal;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - pbas_tmr_t'(1);
    end
  end

  // Done does not look at load, so the sequencer can feed load from its
  // next state without closing a combinational loop.
  assign done = (cnt_reg == '0);
endmodule

// file: design/pbas_initiator.sv
`timescale 1ns/1ps
`include "pbas_regs.svh"
// What this block does
// - Lines are low-true; controls open-collector only.
// - Target requests, initiator acknowledges each byte.
// - Only the initiator drives attention.
// - One byte per handshake, no shared clock.
// - Bit 7 most significant and highest priority.
// - Optional odd parity, ignored during arbitration.
// - Each port owns one data line identity.
// - Arbitration drives identity open-collector only.
// - Exactly one phase; unused lines stay released.
// - Arbitration optional; single initiator without it.
// - Wait bus-free to bus-set, then assert busy.
// - Foreign select seen: release busy and identity.
// - After arbitration delay, lose to higher identity.
// - Winner asserts select, then holds a settle.
// - No arbitration: settle, identities, select later.
// - Arbitration: identities, then release busy later.
// - Two deskews after target busy, release select.
// - Initiator alone drives acknowledge, attention, output.
// - Bus free needs busy and select released.
module pbas_initiator
  import pbas_pkg::*;
#(
  parameter int DESKEW_CYC = `PBAS_DESKEW_CYC,
  parameter int BUS_FREE_CYC = `PBAS_BUS_FREE_CYC,
  parameter int BUS_SET_CYC = `PBAS_BUS_SET_CYC,
  parameter int BUS_CLEAR_CYC = `PBAS_BUS_CLEAR_CYC,
  parameter int ARB_CYC = `PBAS_ARB_CYC,
  parameter int SETTLE_CYC = `PBAS_SETTLE_CYC,
  parameter int SEL_TIMEOUT_CYC = `PBAS_SEL_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic startReq,
  input wire logic arbEnable,
  input wire logic parityEnable,
  input wire pbas_id_t ownId,
  input wire pbas_id_t targetId,
  input wire logic attnReq,
  input wire pbas_byte_t txByte,
  input wire logic txValid,
  output logic txTaken,
  output pbas_byte_t rxByte,
  output logic rxValid,
  output logic rxParityErr,
  output logic rxCtl,
  output logic rxMsg,
  output logic connected,
  output logic selDone,
  output logic selFail,
  output logic arbLost,
  output logic linkEnd,
  input wire logic bsyIn,
  output logic bsyOut,
  output logic bsyOeN,
  input wire logic selIn,
  output logic selOut,
  output logic selOeN,
  input wire logic ackIn,
  output logic ackOut,
  output logic ackOeN,
  input wire logic atnIn,
  output logic atnOut,
  output logic atnOeN,
  input wire logic cdIn,
  input wire logic ioIn,
  input wire logic reqIn,
  input wire logic msgIn,
  input wire logic rstIn,
  input wire pbas_byte_t dataIn,
  output pbas_byte_t dataOut,
  output pbas_byte_t dataOeN,
  input wire logic parIn,
  output logic parOut,
  output logic parOeN
);
  // ------------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------------
  // The data line that carries one identity.
  function automatic pbas_byte_t idBit(input pbas_id_t id);
    idBit = 8'h01 << id;
  endfunction

  // Every data line of higher priority than the given identity.
  function automatic pbas_byte_t higherMask(input pbas_id_t id);
    higherMask = 8'hfe << id;
  endfunction

  // Parity bit that makes the nine lines odd.
  function automatic logic oddPar(input pbas_byte_t d);
    oddPar = ~^d;
  endfunction

  // ------------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------------
  pbas_state_t state_reg; // Current sequencer state.
  pbas_state_t state_next; // Sequencer state for the next cycle.
  pbas_tmr_t stayCnt_reg; // Cycles spent in the current state.
  pbas_tmr_t loadVal; // Timer value for the state being entered.
  logic tDone; // Timer has run out.
  logic bsyA, selA, rstA, cdA, ioA, reqA, msgA, parA, busFree;
  pbas_byte_t dataA; // Data lines as asserted bits.
  pbas_byte_t txHold_reg; // Outgoing byte held through the handshake.
  logic outDir_reg; // The current handshake moves a byte out.
  logic pinLow_reg; // Level put on a line whenever it is pulled.
  logic bsyDrv, selDrv, ackDrv, atnDrv, parDrv; // Next drive decisions.
  pbas_byte_t dataDrv; // Next data lines to pull.
  logic dataOn; // The data lines carry both selection identities or a byte next cycle.
  logic enter; // A state change happens at the next edge.

  // ------------------------------------------------------------------------
  // Line sampling and timer
  // ------------------------------------------------------------------------
  pbas_bus_sampler #(.DESKEW_CYC(DESKEW_CYC)) uSampler (
    .mclk(mclk), .resetn(resetn), .bsyIn(bsyIn), .selIn(selIn), .rstIn(rstIn),
    .cdIn(cdIn), .ioIn(ioIn), .reqIn(reqIn), .msgIn(msgIn), .dataIn(dataIn),
    .parIn(parIn), .bsyA(bsyA), .selA(selA), .rstA(rstA), .cdA(cdA), .ioA(ioA),
    .reqA(reqA), .msgA(msgA), .dataA(dataA), .parA(parA), .busFree(busFree)
  );

  pbas_delay_timer uTimer (
    .mclk(mclk), .resetn(resetn), .load(enter), .loadVal(loadVal), .done(tDone)
  );

  assign enter = (state_next != state_reg);

  // Each state that waits a named delay loads it on entry.
  always_comb begin
    case (state_next)
      ST_FREE_DLY: loadVal = pbas_tmr_t'(arbEnable ? BUS_FREE_CYC : SETTLE_CYC);
      ST_ARB: loadVal = pbas_tmr_t'(ARB_CYC);
      ST_WIN: loadVal = pbas_tmr_t'(SETTLE_CYC);
      ST_IDS, ST_SELHOLD: loadVal = pbas_tmr_t'(2 * DESKEW_CYC);
      ST_SELWAIT: loadVal = pbas_tmr_t'(SEL_TIMEOUT_CYC);
      default: loadVal = '0;
    endcase
  end

  // ------------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------------
  // Next state; a reset condition on the bus drops everything at once.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (startReq) state_next = ST_WAIT_FREE;
      ST_WAIT_FREE: if (busFree) state_next = ST_FREE_DLY;
      ST_FREE_DLY: begin
        // Arbitration waits the bus-free delay; without it, the settle.
        if (!busFree) state_next = ST_WAIT_FREE;
        else if (tDone) state_next = arbEnable ? ST_ARB : ST_IDS;
      end
      ST_ARB: begin
        if (selA) state_next = ST_WAIT_FREE;
        else if (tDone && |(dataA & higherMask(ownId))) state_next = ST_WAIT_FREE;
        else if (tDone) state_next = ST_WIN;
      end
      ST_WIN: if (tDone) state_next = ST_IDS;
      ST_IDS: if (tDone) state_next = ST_SELWAIT;
      ST_SELWAIT: begin
        // Our own busy release needs a few cycles to leave the sampler.
        if (bsyA && stayCnt_reg > pbas_tmr_t'(`PBAS_PIPE_CYC)) begin
          state_next = ST_SELHOLD;
        end else if (tDone) begin
          state_next = ST_IDLE;
        end
      end
      ST_SELHOLD: if (tDone) state_next = ST_XFER;
      ST_XFER: begin
        // Target dropping busy ends the connection.
        if (!bsyA) state_next = ST_IDLE;
        else if (reqA && (ioA || txValid)) state_next = ST_ACK;
      end
      ST_ACK: if (!reqA) state_next = ST_XFER;
      default: state_next = ST_IDLE;
    endcase
    if (rstA) state_next = ST_IDLE;
  end

  // State register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Dwell counter, saturating, also used to mask sampler latency.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) stayCnt_reg <= '0;
    else if (enter) stayCnt_reg <= '0;
    else if (stayCnt_reg != '1) stayCnt_reg <= stayCnt_reg + pbas_tmr_t'(1);
  end

  // ------------------------------------------------------------------------
  // Line drive decode
  // ------------------------------------------------------------------------
  // Each line is pulled only in the states that call for it and is released
  // everywhere else, so stale drive can never leak across phases.
  always_comb begin
    bsyDrv = (state_next == ST_ARB) || (state_next == ST_WIN) ||
             (state_next == ST_IDS && arbEnable);
    selDrv = (state_next == ST_WIN) || (state_next == ST_IDS && arbEnable) ||
             (state_next == ST_SELWAIT) || (state_next == ST_SELHOLD);
    ackDrv = (state_next == ST_ACK);
    atnDrv = attnReq && (state_next == ST_XFER || state_next == ST_ACK);
    dataDrv = 8'h00;
    dataOn = 1'b0;
    parDrv = 1'b0;
    case (state_next)
      ST_ARB, ST_WIN: dataDrv = idBit(ownId);
      ST_IDS, ST_SELWAIT, ST_SELHOLD: begin
        dataDrv = idBit(ownId) | idBit(targetId);
        dataOn = 1'b1;
      end
      ST_ACK: begin
        // Outgoing data only while the target asks for output.
        if (state_reg == ST_XFER && !ioA) begin
          dataDrv = txByte;
          dataOn = 1'b1;
        end else if (state_reg == ST_ACK && outDir_reg) begin
          dataDrv = txHold_reg;
          dataOn = 1'b1;
        end
      end
      default: dataDrv = 8'h00;
    endcase
    // Parity stays released during arbitration where it has no meaning.
    // It is the odd parity of the driven value, so that an
    // all-zero byte still carries its asserted parity bit.
    if (parityEnable && state_next != ST_ARB && state_next != ST_WIN) begin
      parDrv = dataOn && oddPar(dataDrv);
    end
  end

  // Pulled lines: enable low means we pull the line low (asserted).
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {bsyOeN, selOeN, ackOeN, atnOeN, parOeN} <= 5'h1f;
      dataOeN <= 8'hff;
    end else begin
      {bsyOeN, selOeN, ackOeN, atnOeN} <= ~{bsyDrv, selDrv, ackDrv, atnDrv};
      parOeN <= ~parDrv;
      dataOeN <= ~dataDrv;
    end
  end

  // Open-collector style everywhere: the driven level is always low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pinLow_reg <= 1'b0;
    else pinLow_reg <= 1'b0;
  end

  assign bsyOut = pinLow_reg;
  assign selOut = pinLow_reg;
  assign ackOut = pinLow_reg;
  assign atnOut = pinLow_reg;
  assign parOut = pinLow_reg;
  assign dataOut = {`PBAS_DATA_W{pinLow_reg}};

  // ------------------------------------------------------------------------
  // Byte transfer
  // ------------------------------------------------------------------------
  // A request in input direction captures the byte and its phase lines; in
  // output direction the user byte is latched and held until request drops.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {rxValid, txTaken, rxParityErr, rxCtl, rxMsg, outDir_reg} <= 6'h00;
      rxByte <= 8'h00;
      txHold_reg <= 8'h00;
    end else begin
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      if (state_reg == ST_XFER && state_next == ST_ACK) begin
        outDir_reg <= !ioA;
        rxCtl <= cdA;
        rxMsg <= msgA;
        if (ioA) begin
          rxByte <= dataA;
          rxValid <= 1'b1;
          rxParityErr <= parityEnable && (parA != oddPar(dataA));
        end else begin
          txHold_reg <= txByte;
          txTaken <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------------
  // Status reporting
  // ------------------------------------------------------------------------
  // Event pulses and the connected level follow the sequencer edges.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {connected, selDone, selFail, arbLost, linkEnd} <= 5'h00;
    end else begin
      connected <= (state_next == ST_XFER) || (state_next == ST_ACK);
      selDone <= (state_reg == ST_SELHOLD) && (state_next == ST_XFER);
      selFail <= (state_reg == ST_SELWAIT) && (state_next == ST_IDLE);
      arbLost <= (state_reg == ST_ARB) && (state_next == ST_WAIT_FREE);
      linkEnd <= (state_reg == ST_XFER || state_reg == ST_ACK) && (state_next == ST_IDLE);
    end
  end

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  sequence s_reqIn;
    state_reg == ST_XFER && bsyA && reqA && ioA && !rstA;
  endsequence

  sequence s_ackUp;
    !ackOeN && rxValid;
  endsequence

  property p_arbOwnIdOnly;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_ARB |-> dataOeN == ~idBit(ownId) && parOeN;
  endproperty
  a_arbOwnIdOnly: assert property (p_arbOwnIdOnly) else $error("arbitration drive wrong");

  property p_selWithdraw;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_ARB && selA |-> ##[1:BUS_CLEAR_CYC] (bsyOeN && &dataOeN);
  endproperty
  a_selWithdraw: assert property (p_selWithdraw) else $error("no withdraw on select");

  property p_freeWait;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_FREE_DLY && state_next == ST_ARB |->
      stayCnt_reg >= pbas_tmr_t'(BUS_FREE_CYC) && stayCnt_reg <= pbas_tmr_t'(BUS_SET_CYC);
  endproperty
  a_freeWait: assert property (p_freeWait) else $error("busy asserted outside window");

  property p_loseHigher;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_ARB && tDone && !rstA && |(dataA & higherMask(ownId))
      |=> state_reg == ST_WAIT_FREE ##1 bsyOeN;
  endproperty
  a_loseHigher: assert property (p_loseHigher) else $error("did not yield");

  property p_winSettle;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_WIN && state_next != ST_WIN && !rstA |->
      stayCnt_reg >= pbas_tmr_t'(SETTLE_CYC);
  endproperty
  a_winSettle: assert property (p_winSettle) else $error("settle cut short");

  property p_idsDeskew;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_SELWAIT && $past(state_reg) == ST_IDS |->
      $past(stayCnt_reg) >= pbas_tmr_t'(2 * DESKEW_CYC) && !selOeN;
  endproperty
  a_idsDeskew: assert property (p_idsDeskew) else $error("select step too early");

  property p_ackExclusive;
    @(posedge mclk) disable iff (!resetn)
    !ackOeN |-> selOeN && bsyOeN;
  endproperty
  a_ackExclusive: assert property (p_ackExclusive) else $error("ack while selecting");

  property p_inputNoDrive;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_ACK && !outDir_reg |-> &dataOeN;
  endproperty
  a_inputNoDrive: assert property (p_inputNoDrive) else $error("data driven on input");

  property p_ackAnswer;
    @(posedge mclk) disable iff (!resetn)
    s_reqIn |=> s_ackUp;
  endproperty
  a_ackAnswer: assert property (p_ackAnswer) else $error("request not acknowledged");

  property p_busFreeSeen;
    @(posedge mclk) disable iff (!resetn)
    state_reg == ST_WAIT_FREE && state_next == ST_FREE_DLY |->
      !bsyA && !selA && !rstA && $past(!bsyA && !selA);
  endproperty
  a_busFreeSeen: assert property (p_busFreeSeen) else $error("bus free not qualified");
endmodule

// file: design/pbas_pkg.sv
`include "pbas_regs.svh"
package pbas_pkg;
  // ------------------------------------------------------------------------
  // Types shared by the controller files
  // ------------------------------------------------------------------------
  // Delay timer and dwell counter value.
  typedef logic [`PBAS_TMR_W-1:0] pbas_tmr_t;
  // One bus device identity number.
  typedef logic [`PBAS_ID_W-1:0] pbas_id_t;
  // One byte of the data bus.
  typedef logic [`PBAS_DATA_W-1:0] pbas_byte_t;
  // Sequencer states of the initiator.
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_FREE, ST_FREE_DLY, ST_ARB, ST_WIN, ST_IDS,
    ST_SELWAIT, ST_SELHOLD, ST_XFER, ST_ACK
  } pbas_state_t;
endpackage

// file: design/pbas_regs.svh
`ifndef PBAS_REGS_SVH
`define PBAS_REGS_SVH
// --------------------------------------------------------------------------
// Clock rate and conversion of times into clock cycles
// --------------------------------------------------------------------------
// The core clock period in nanoseconds.
`define PBAS_CLK_NS 5
// A least time rounds up to whole cycles.
`define PBAS_CYC_UP(ns) (((ns) + `PBAS_CLK_NS - 1) / `PBAS_CLK_NS)
// A longest time rounds down, but never below one cycle.
`define PBAS_CYC_DN(ns) (((ns) < `PBAS_CLK_NS) ? 1 : ((ns) / `PBAS_CLK_NS))
// --------------------------------------------------------------------------
// Named bus delays in nanoseconds
// --------------------------------------------------------------------------
`define PBAS_DESKEW_NS 50
`define PBAS_BUS_FREE_NS 800
`define PBAS_BUS_SET_NS 1600
`define PBAS_BUS_CLEAR_NS 800
`define PBAS_ARB_NS 2400
`define PBAS_SETTLE_NS 400
`define PBAS_SEL_TIMEOUT_NS 20000
// --------------------------------------------------------------------------
// The same delays as cycle counts
// --------------------------------------------------------------------------
`define PBAS_DESKEW_CYC `PBAS_CYC_UP(`PBAS_DESKEW_NS)
`define PBAS_BUS_FREE_CYC `PBAS_CYC_UP(`PBAS_BUS_FREE_NS)
`define PBAS_BUS_SET_CYC `PBAS_CYC_DN(`PBAS_BUS_SET_NS)
`define PBAS_BUS_CLEAR_CYC `PBAS_CYC_DN(`PBAS_BUS_CLEAR_NS)
`define PBAS_ARB_CYC `PBAS_CYC_UP(`PBAS_ARB_NS)
`define PBAS_SETTLE_CYC `PBAS_CYC_UP(`PBAS_SETTLE_NS)
`define PBAS_SEL_TIMEOUT_CYC `PBAS_CYC_DN(`PBAS_SEL_TIMEOUT_NS)
// --------------------------------------------------------------------------
// Widths and pipeline figures
// --------------------------------------------------------------------------
// Cycles from a drive decision until our own level is seen at the sampler.
`define PBAS_PIPE_CYC 3
`define PBAS_TMR_W 12
`define PBAS_ID_W 3
`define PBAS_DATA_W 8
`endif

// file: tb/pbas_target_model.sv
`timescale 1ns/1ps
module pbas_target_model
  import pbas_pkg::*;
(
  input wire logic mclk,
  input wire logic bsyW,
  input wire logic selW,
  input wire logic ackW,
  input wire pbas_byte_t dataW,
  input wire logic parW,
  input wire pbas_id_t myId,
  input wire pbas_byte_t inByte,
  input wire logic inCtl,
  input wire logic [7:0] dly,
  output logic tBsy,
  output logic tCd,
  output logic tIo,
  output logic tReq,
  output logic tMsg,
  output pbas_byte_t tData,
  output logic tPar,
  output pbas_byte_t gotOut,
  output logic gotPar
);
  // A 1 on any bus output (all but gotOut and gotPar) pulls its low-true line to the asserted level.
  initial {tBsy, tCd, tIo, tReq, tMsg, tData, tPar, gotOut, gotPar} = '0;
  // Answer a selection, send one byte in, take one byte out, then free the bus.
  always begin
    @(posedge mclk);
    if (!selW && !dataW[myId] && bsyW) begin
      repeat (dly) @(posedge mclk);
      tBsy <= 1'b1;
      wait (selW);
      @(posedge mclk);
      tIo <= 1'b1;
      tCd <= inCtl;
      tMsg <= inCtl;
      tData <= inByte;
      tPar <= ~^inByte;
      repeat (dly + 2) @(posedge mclk);
      tReq <= 1'b1;
      wait (!ackW);
      @(posedge mclk);
      tReq <= 1'b0;
      wait (ackW);
      @(posedge mclk);
      {tIo, tCd, tMsg, tData, tPar} <= '0;
      repeat (dly + 2) @(posedge mclk);
      tReq <= 1'b1;
      wait (!ackW);
      repeat (2) @(posedge mclk);
      gotOut <= ~dataW;
      gotPar <= ~parW;
      tReq <= 1'b0;
      wait (ackW);
      @(posedge mclk);
      tBsy <= 1'b0;
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pbas_pkg::*;
  logic mclk = 0, resetn = 0, startReq = 0, arbEnable = 0, attnReq = 0;
  logic txValid = 0, inCtl = 0, cBsy = 0, parEn = 0, busRstN = 1, cSel = 0;
  pbas_id_t ownId = 0, targetId = 1, mId = 1;
  pbas_byte_t txByte = 0, inByte = 0, cData = 0, rxByte, dataOeN, tData, gotOut, dataOut;
  logic [7:0] dly = 0;
  logic txTaken, rxValid, rxParityErr, rxCtl, rxMsg, connected, selDone, selFail;
  logic arbLost, linkEnd, bsyOeN, selOeN, ackOeN, atnOeN, parOeN;
  logic tBsy, tCd, tIo, tReq, tMsg, tPar, gotPar;
  logic bsyOut, selOut, ackOut, atnOut, parOut;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  pbas_byte_t expQ[$];
  // Pulled-up lines: low while any party pulls.
  wire bsyW = (bsyOeN | bsyOut) & ~tBsy & ~cBsy;
  wire selW = (selOeN | selOut) & ~cSel;
  wire ackW = ackOeN | ackOut;
  wire atnW = atnOeN | atnOut;
  wire pbas_byte_t dataW = (dataOeN | dataOut) & ~tData & ~cData;
  wire parW = (parOeN | parOut) & ~tPar;
  always #2.5 mclk = ~mclk;
  pbas_initiator #(.DESKEW_CYC(2), .BUS_FREE_CYC(8), .BUS_SET_CYC(16), .BUS_CLEAR_CYC(8),
    .ARB_CYC(10), .SETTLE_CYC(4), .SEL_TIMEOUT_CYC(60)) uut (.mclk(mclk), .resetn(resetn),
    .startReq(startReq), .arbEnable(arbEnable), .parityEnable(parEn), .ownId(ownId),
    .targetId(targetId), .attnReq(attnReq), .txByte(txByte), .txValid(txValid),
    .txTaken(txTaken), .rxByte(rxByte), .rxValid(rxValid), .rxParityErr(rxParityErr),
    .rxCtl(rxCtl), .rxMsg(rxMsg), .connected(connected), .selDone(selDone),
    .selFail(selFail), .arbLost(arbLost), .linkEnd(linkEnd), .bsyIn(bsyW), .bsyOut(bsyOut),
    .bsyOeN(bsyOeN), .selIn(selW), .selOut(selOut), .selOeN(selOeN), .ackIn(ackW),
    .ackOut(ackOut), .ackOeN(ackOeN), .atnIn(atnW), .atnOut(atnOut), .atnOeN(atnOeN),
    .cdIn(~tCd), .ioIn(~tIo), .reqIn(~tReq), .msgIn(~tMsg), .rstIn(busRstN),
    .dataIn(dataW), .dataOut(dataOut), .dataOeN(dataOeN), .parIn(parW), .parOut(parOut),
    .parOeN(parOeN));
  pbas_target_model tgt (.mclk(mclk), .bsyW(bsyW), .selW(selW), .ackW(ackW),
    .dataW(dataW), .parW(parW), .myId(mId), .inByte(inByte), .inCtl(inCtl), .dly(dly),
    .tBsy(tBsy), .tCd(tCd), .tIo(tIo), .tReq(tReq), .tMsg(tMsg), .tData(tData),
    .tPar(tPar), .gotOut(gotOut), .gotPar(gotPar));
  // Counts every comparison and reports a mismatch at once.
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits for a flag at falling edges, where outputs are settled.
  task automatic until1(ref logic s);
    do @(negedge mclk); while (s !== 1'b1);
  endtask
  // One selection attempt with random identities, bytes and target pace.
  task automatic session(input logic arb, input logic fail, input logic [1:0] race);
    int o, t;
    o = $urandom_range(6);
    t = (o + 1 + $urandom_range(5)) % 7;
    @(posedge mclk);
    {ownId, targetId, mId} <= {o[2:0], t[2:0], fail ? 3'h7 : t[2:0]};
    {arbEnable, inByte, txByte, inCtl, attnReq} <= {arb, 16'($urandom), 2'($urandom)};
    dly <= 8'($urandom_range(9));
    parEn <= 1'($urandom);
    startReq <= 1'b1;
    txValid <= 1'b1;
    @(posedge mclk);
    startReq <= 1'b0;
    if (race != 2'h0) begin
      do @(negedge mclk); while (bsyOeN !== 1'b0);
      @(posedge mclk);
      {cBsy, cSel, cData} <= {1'b1, race[1], 8'h80};
      until1(arbLost);
      @(negedge mclk);
      chk("arb_release", {1'b1, 7'h7f}, {bsyOeN, dataOeN[6:0]});
      @(posedge mclk);
      {cBsy, cSel, cData} <= '0;
    end
    if (fail) begin
      until1(selFail);
      chk("sel_fail_release", 8'h01, {7'h0, selOeN});
      return;
    end
    expQ.push_back(inByte);
    until1(selDone);
    until1(rxValid);
    chk("rxByte", expQ.pop_front(), rxByte);
    chk("rxCtlMsg", {2{inCtl}}, {rxCtl, rxMsg});
    chk("rxParityErr", 8'h00, {7'h0, rxParityErr});
    chk("attn", {7'h0, ~attnReq}, {7'h0, atnOeN});
    until1(txTaken);
    @(posedge mclk);
    txValid <= 1'b0;
    until1(linkEnd);
    chk("outByte", txByte, gotOut);
    chk("outPar", {7'h0, parEn & ~^txByte}, {7'h0, gotPar});
    chk("connected", 8'h00, {6'h0, connected, ~atnOeN});
  endtask
  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog: a hang counts as a mismatch.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(29));
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    session(1'b1, 1'b0, 2'h1);
    session(1'b1, 1'b0, 2'h3);
    for (int i = 0; i < 6; i++) begin
      session(i[0], 1'b0, 2'h0);
    end
    session(1'b1, 1'b1, 2'h0);
    session(1'b0, 1'b1, 2'h0);
    // A bus reset in mid-selection must drop select, the data lines and connected within a few cycles.
    @(posedge mclk);
    startReq <= 1'b1;
    @(posedge mclk);
    startReq <= 1'b0;
    do @(negedge mclk); while (selOeN !== 1'b0);
    @(posedge mclk);
    busRstN <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("bus_reset_release", 8'h00, {5'h0, connected, ~selOeN, ~&dataOeN});
    @(posedge mclk);
    busRstN <= 1'b1;
    session(1'b1, 1'b0, 2'h0);
    stop_test();
  end
endmodule
